// >>> rtl/gpiors_top.sv
// Purpose : pad control for the low gpio pads, reset states, boot straps
// Assumes : 20 MHz clk, apb slave, pads driven by an outside pad ring
// Notes   : straps are captured once per reset; pads are registered
//
// Overview of operation
// - a low hw_reset_n level holds all logic except the synchroniser and the converter enable in reset.
// - the regulator converter runs while converter_enable is high.
// - the wake pad input stays off until firmware selects its function.
// - with the wake function chosen, a high wake pad wakes a sleeping chip.
// - analog pads stay input-off with no pull-up until firmware sets them.
// - analog_pin_b may be analog input 2, pulse_width_out or gpio.
// - test strap and receive pads are input-off with pull-up in reset.
// - a low test strap sampled at start-up selects manufacturing test.
// - start-up makes the pads primary serial tx and rx with no pulls.
// - download mode drops that serial assignment and turns pull-ups on.
// - a high boot strap with a high test strap sampled at start-up selects download mode.
// - firmware may set tx pad pulls and gpio, serial tx or spi data out.
// - firmware may set rx pad pulls and gpio, serial rx or spi data in.

`timescale 1ns/10ps

module gpiors_top
  import gpiors_pkg::*;
#(
  parameter logic [15:0] STARTUP_CYCLES = STARTUP_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   hw_reset_n,
  input  wire logic                   converter_enable,
  input  wire logic      [NPIN-1:0]   pad_in,
  output gpiors_pad_t    [NPIN-1:0]   pad_ctl,
  input  wire logic                   primary_serial_tx,
  input  wire logic                   secondary_serial_tx,
  input  wire logic                   spi_dout,
  input  wire logic                   pulse_width_out,
  input  wire logic                   sleep_active,
  output logic                        primary_serial_rx,
  output logic                        secondary_serial_rx,
  output logic                        spi_din,
  output logic                        wake_req,
  output logic                        converter_on,
  output logic                        test_mode,
  output logic                        download_mode,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic      [7:0]        paddr,
  input  wire logic      [31:0]       pwdata,
  output logic           [31:0]       prdata,
  output logic                        pready,
  output logic                        pslverr
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [NPIN+1:0]            sync_q;
  logic [NPIN-1:0]            pin_s;
  logic                       hw_rst_s;
  logic                       conv_s;
  logic                       int_rst;
  gpiors_state_t              state_r;
  logic [15:0]                cnt_r;
  logic                       capture;
  logic                       strap_test_r;
  logic                       strap_boot_r;
  logic                       test_mode_r;
  logic                       dl_mode_r;
  logic                       cfg_live;
  logic [31:0]                func_r;
  logic [31:0]                pull_r;
  logic [31:0]                gpio_r;
  logic [31:0]                status;
  logic [31:0]                prdata_r;
  logic                       pready_r;
  logic                       pslverr_r;
  logic                       wr_en;
  gpiors_pad_t [NPIN-1:0]     pad_nxt;
  gpiors_pad_t [NPIN-1:0]     pad_r;
  logic                       pri_rx_r;
  logic                       sec_rx_r;
  logic                       spi_din_r;
  logic                       wake_r;
  logic                       conv_r;

  // ---------------------------------------------------------------
  // pad input synchronisers
  // ---------------------------------------------------------------
  gpiors_sync #(
    .W (NPIN + 2)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({converter_enable, hw_reset_n, pad_in}),
    .q     (sync_q)
  );

  assign pin_s    = sync_q[NPIN-1:0];
  assign hw_rst_s = sync_q[NPIN];
  assign conv_s   = sync_q[NPIN+1];
  // pin reset is a level; filtered through the synchroniser
  assign int_rst  = reset | ~hw_rst_s;

  // ---------------------------------------------------------------
  // converter enable
  // ---------------------------------------------------------------
  // not held by the pin reset: the regulator must run through it
  always_ff @(posedge clk) begin
    if (reset) begin
      conv_r <= 1'b0;
    end else begin
      conv_r <= conv_s;
    end
  end

  // ---------------------------------------------------------------
  // start-up sequencer
  // ---------------------------------------------------------------
  assign capture = (state_r == ST_SAMPLE) &&
                   (cnt_r == SAMPLE_CYC - 16'h0001);

  // timer, then strap sampling window, then normal running
  always_ff @(posedge clk) begin
    if (int_rst) begin
      state_r <= ST_HOLD;
      cnt_r   <= 16'h0000;
    end else begin
      case (state_r)
        ST_HOLD: begin
          state_r <= ST_WAIT;
          cnt_r   <= 16'h0000;
        end
        ST_WAIT: begin
          if (cnt_r == STARTUP_CYCLES - 16'h0001) begin
            state_r <= ST_SAMPLE;
            cnt_r   <= 16'h0000;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        ST_SAMPLE: begin
          if (capture) begin
            state_r <= ST_ACTIVE;
            cnt_r   <= 16'h0000;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        ST_ACTIVE: begin
          state_r <= ST_ACTIVE;
        end
        default: begin
          state_r <= ST_HOLD;
          cnt_r   <= 16'h0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // one capture per reset; test mode outranks download mode
  always_ff @(posedge clk) begin
    if (int_rst) begin
      strap_test_r <= 1'b1;
      strap_boot_r <= 1'b0;
      test_mode_r  <= 1'b0;
      dl_mode_r    <= 1'b0;
    end else if (capture) begin
      strap_test_r <= pin_s[PIN_TX];
      strap_boot_r <= pin_s[PIN_BOOT];
      test_mode_r  <= ~pin_s[PIN_TX];
      dl_mode_r    <= pin_s[PIN_TX] & pin_s[PIN_BOOT];
    end
  end

  // ---------------------------------------------------------------
  // apb slave: zero wait states
  // ---------------------------------------------------------------
  assign wr_en = psel & penable & pwrite & pready_r;

  assign status = {19'h0, (state_r == ST_ACTIVE), dl_mode_r, test_mode_r,
                   strap_boot_r, strap_test_r, 2'h0, pin_s};

  // writes land on the access edge; status is read-only
  always_ff @(posedge clk) begin
    if (int_rst) begin
      func_r <= FUNC_RST;
      pull_r <= PULL_RST;
      gpio_r <= GPIO_RST;
    end else if (wr_en) begin
      if (paddr == FUNC_OFS) begin
        func_r <= {20'h0, pwdata[11:0]};
      end else if (paddr == PULL_OFS) begin
        pull_r <= {18'h0, pwdata[13:8], 2'h0, pwdata[5:0]};
      end else if (paddr == GPIO_OFS) begin
        gpio_r <= {18'h0, pwdata[13:8], 2'h0, pwdata[5:0]};
      end
    end
  end

  // read data and error are set up in the setup phase
  always_ff @(posedge clk) begin
    if (int_rst) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pready_r  <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (psel && !penable) begin
        pslverr_r <= 1'b0;
        if (paddr == FUNC_OFS) begin
          prdata_r <= func_r;
        end else if (paddr == PULL_OFS) begin
          prdata_r <= pull_r;
        end else if (paddr == GPIO_OFS) begin
          prdata_r <= gpio_r;
        end else if (paddr == STAT_OFS) begin
          prdata_r <= status;
        end else begin
          prdata_r  <= 32'h0000_0000;
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pad state selection
  // ---------------------------------------------------------------
  assign cfg_live = (state_r == ST_ACTIVE) && !dl_mode_r;

  // reset pattern, sampling pattern, download pattern, firmware config
  always_comb begin
    pad_nxt = '0;
    if (cfg_live) begin
      for (int i = 0; i < NPIN; i++) begin
        pad_nxt[i].pu = pull_r[i];
        pad_nxt[i].pd = pull_r[HI_POS+i];
        if (((i == PIN_TX || i == PIN_RX) && func_r[2*i +: 2] == FN_SGP) ||
            (i != PIN_TX && i != PIN_RX && func_r[2*i +: 2] == FN_GPIO)) begin
          pad_nxt[i].ie  = 1'b1;
          pad_nxt[i].oe  = gpio_r[HI_POS+i];
          pad_nxt[i].out = gpio_r[i];
        end
      end
      if (func_r[2*PIN_WAKE +: 2] == FN_ALT1) begin
        pad_nxt[PIN_WAKE].ie = 1'b1;
      end
      if (func_r[2*PIN_ANA +: 2] == FN_ALT1) begin
        pad_nxt[PIN_ANA].ana = 1'b1;
      end
      if (func_r[2*PIN_ANB +: 2] == FN_ALT1) begin
        pad_nxt[PIN_ANB].ana = 1'b1;
      end else if (func_r[2*PIN_ANB +: 2] == FN_ALT2) begin
        pad_nxt[PIN_ANB].oe  = 1'b1;
        pad_nxt[PIN_ANB].out = pulse_width_out;
      end
      if (func_r[2*PIN_TX +: 2] != FN_SGP) begin
        pad_nxt[PIN_TX].oe = 1'b1;
        case (func_r[2*PIN_TX +: 2])
          FN_PRI:  pad_nxt[PIN_TX].out = primary_serial_tx;
          FN_SEC:  pad_nxt[PIN_TX].out = secondary_serial_tx;
          default: pad_nxt[PIN_TX].out = spi_dout;
        endcase
      end
      if (func_r[2*PIN_RX +: 2] != FN_SGP) begin
        pad_nxt[PIN_RX].ie = 1'b1;
      end
    end else if (state_r == ST_ACTIVE) begin
      // serial assignment dropped, pull-ups on for the host
      pad_nxt[PIN_TX].pu = 1'b1;
      pad_nxt[PIN_RX].pu = 1'b1;
      pad_nxt[PIN_TX].ie = 1'b1;
      pad_nxt[PIN_RX].ie = 1'b1;
      pad_nxt[PIN_BOOT].pu = 1'b1;
      pad_nxt[PIN_BOOT].ie = 1'b1;
    end else if (state_r == ST_SAMPLE) begin
      // pull-up stays on while the straps are read
      pad_nxt[PIN_TX].pu   = 1'b1;
      pad_nxt[PIN_TX].ie   = 1'b1;
      pad_nxt[PIN_BOOT].pu = 1'b1;
      pad_nxt[PIN_BOOT].ie = 1'b1;
      pad_nxt[PIN_RX].pu   = 1'b1;
    end else begin
      pad_nxt[PIN_TX].pu   = 1'b1;
      pad_nxt[PIN_RX].pu   = 1'b1;
      pad_nxt[PIN_BOOT].pu = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registered pad and peripheral outputs
  // ---------------------------------------------------------------
  // the rx lines idle high so a parked uart sees no start bit
  always_ff @(posedge clk) begin
    if (int_rst) begin
      // strap and receive pull-ups must already hold during reset
      pad_r              <= '0;
      pad_r[PIN_TX].pu   <= 1'b1;
      pad_r[PIN_RX].pu   <= 1'b1;
      pad_r[PIN_BOOT].pu <= 1'b1;
      pri_rx_r  <= 1'b1;
      sec_rx_r  <= 1'b1;
      spi_din_r <= 1'b0;
      wake_r    <= 1'b0;
    end else begin
      pad_r     <= pad_nxt;
      pri_rx_r  <= (cfg_live && func_r[2*PIN_RX +: 2] == FN_PRI) ?
                   pin_s[PIN_RX] : 1'b1;
      sec_rx_r  <= (cfg_live && func_r[2*PIN_RX +: 2] == FN_SEC) ?
                   pin_s[PIN_RX] : 1'b1;
      spi_din_r <= (cfg_live && func_r[2*PIN_RX +: 2] == FN_SPI) ?
                   pin_s[PIN_RX] : 1'b0;
      wake_r    <= cfg_live && sleep_active && pad_r[PIN_WAKE].ie &&
                   func_r[2*PIN_WAKE +: 2] == FN_ALT1 &&
                   pin_s[PIN_WAKE];
    end
  end

  assign pad_ctl             = pad_r;
  assign primary_serial_rx   = pri_rx_r;
  assign secondary_serial_rx = sec_rx_r;
  assign spi_din             = spi_din_r;
  assign wake_req            = wake_r;
  assign converter_on        = conv_r;
  assign test_mode           = test_mode_r;
  assign download_mode       = dl_mode_r;
  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_reset_inputs_off: assert property (
    @(posedge clk) int_rst |=> (pad_r[PIN_WAKE].ie == 1'b0) &&
      (pad_r[PIN_ANA].ie == 1'b0) && (pad_r[PIN_TX].oe == 1'b0))
    else $error("pads not input-off after reset");

  a_converter_follow: assert property (
    @(posedge clk) disable iff (reset) conv_s |=> conv_r)
    else $error("converter not on with enable high");

  a_wake_ie_gated: assert property (
    @(posedge clk) disable iff (int_rst)
    $rose(pad_r[PIN_WAKE].ie) |-> $past(state_r) == ST_ACTIVE)
    else $error("wake input enabled before firmware");

  a_wake_request: assert property (
    @(posedge clk) disable iff (int_rst)
    (cfg_live && sleep_active && pad_r[PIN_WAKE].ie && pin_s[PIN_WAKE] &&
     func_r[1:0] == FN_ALT1) |=> wake_req)
    else $error("wake event missed");

  a_analog_quiet: assert property (
    @(posedge clk) disable iff (int_rst) (state_r != ST_ACTIVE) |=>
      !pad_r[PIN_ANA].ie && !pad_r[PIN_ANA].pu && !pad_r[PIN_ANB].ie)
    else $error("analog pad active before firmware");

  a_pwm_route: assert property (
    @(posedge clk) disable iff (int_rst)
    (cfg_live && func_r[5:4] == FN_ALT2) |=>
      pad_r[PIN_ANB].oe && pad_r[PIN_ANB].out == $past(pulse_width_out))
    else $error("pulse output not routed");

  a_strap_pullups: assert property (
    @(posedge clk) int_rst |=> pad_r[PIN_TX].pu && pad_r[PIN_RX].pu)
    else $error("strap pull-up off in reset");

  a_test_strap_low: assert property (
    @(posedge clk) disable iff (int_rst)
    (capture && !pin_s[PIN_TX]) |=> test_mode_r && !dl_mode_r)
    else $error("test mode not entered");

  a_default_tx: assert property (
    @(posedge clk) disable iff (int_rst)
    (cfg_live && func_r[7:6] == FN_PRI) |=> pad_r[PIN_TX].oe &&
      pad_r[PIN_TX].out == $past(primary_serial_tx))
    else $error("primary tx not on pad");

  a_download_pads: assert property (
    @(posedge clk) disable iff (int_rst)
    (state_r == ST_ACTIVE && dl_mode_r) |=> !pad_r[PIN_TX].oe &&
      pad_r[PIN_TX].pu && pad_r[PIN_RX].pu && primary_serial_rx)
    else $error("download pads wrong");

  a_boot_strap_high: assert property (
    @(posedge clk) disable iff (int_rst)
    (capture && pin_s[PIN_TX] && pin_s[PIN_BOOT]) |=> dl_mode_r)
    else $error("download mode not entered");

  a_strap_hold: assert property (
    @(posedge clk) disable iff (int_rst)
    (state_r == ST_ACTIVE) |=> $stable(strap_test_r) &&
      $stable(strap_boot_r))
    else $error("strap changed after capture");

  c_normal_run: cover property (
    @(posedge clk) disable iff (int_rst) capture ##1 cfg_live);
  c_download: cover property (
    @(posedge clk) disable iff (int_rst) $rose(dl_mode_r));
  c_test: cover property (
    @(posedge clk) disable iff (int_rst) $rose(test_mode_r));
  c_wake: cover property (
    @(posedge clk) disable iff (int_rst) $rose(wake_req));

endmodule

// >>> rtl/gpiors_pkg.sv
// Purpose : shared constants and types for the gpio reset/strap pad block
// Assumes : 20 MHz single clock, apb register access
// Notes   : pad index order is fixed; offsets are byte addresses

package gpiors_pkg;

  // ---------------------------------------------------------------
  // clock and start-up timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int STARTUP_TIME_NS = 1000000;  // internal start-up timer
  localparam int SETTLE_TIME_NS  = 200;      // strap pull-up settle window
  // least times round up to whole cycles
  localparam logic [15:0] STARTUP_CYC =
    16'((STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SAMPLE_CYC =
    16'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // pad indices
  // ---------------------------------------------------------------
  localparam int NPIN     = 6;
  localparam int PIN_WAKE = 0;  // wake_pin
  localparam int PIN_ANA  = 1;  // analog_pin_a
  localparam int PIN_ANB  = 2;  // analog_pin_b
  localparam int PIN_TX   = 3;  // test_strap_pin
  localparam int PIN_RX   = 4;  // default_rx_pin
  localparam int PIN_BOOT = 5;  // boot_mode_strap_pin

  // ---------------------------------------------------------------
  // register map and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0]  FUNC_OFS = 8'h00;  // 2-bit function per pad
  localparam logic [7:0]  PULL_OFS = 8'h04;  // pull-up [5:0], pull-down
  localparam logic [7:0]  GPIO_OFS = 8'h08;  // out [5:0], oe
  localparam logic [7:0]  STAT_OFS = 8'h0C;  // read-only status
  localparam int          HI_POS   = 8;      // pull-down / oe field base
  localparam int          ST_TEST  = 8;      // captured test strap
  localparam int          ST_BOOT  = 9;      // captured boot strap
  localparam int          ST_TMODE = 10;
  localparam int          ST_DMODE = 11;
  localparam int          ST_RUN   = 12;
  localparam logic [31:0] FUNC_RST = 32'h0000_0140;  // tx/rx primary
  localparam logic [31:0] PULL_RST = 32'h0000_0000;
  localparam logic [31:0] GPIO_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // function codes
  // ---------------------------------------------------------------
  localparam logic [1:0] FN_OFF  = 2'h0;  // wake/analog/boot pads
  localparam logic [1:0] FN_GPIO = 2'h1;
  localparam logic [1:0] FN_ALT1 = 2'h2;  // wake, analog input
  localparam logic [1:0] FN_ALT2 = 2'h3;  // pulse_width_out
  localparam logic [1:0] FN_SGP  = 2'h0;  // serial pads: gpio
  localparam logic [1:0] FN_PRI  = 2'h1;  // primary serial
  localparam logic [1:0] FN_SEC  = 2'h2;  // secondary serial
  localparam logic [1:0] FN_SPI  = 2'h3;  // serial-peripheral data

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ana;  // analog input switch closed
    logic pd;   // pull-down on
    logic pu;   // pull-up on
    logic ie;   // input buffer enabled
    logic oe;   // output driver on
    logic out;  // output level
  } gpiors_pad_t;

  typedef enum logic [3:0] {
    ST_HOLD   = 4'b0001,
    ST_WAIT   = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_ACTIVE = 4'b1000
  } gpiors_state_t;

endpackage

// >>> rtl/gpiors_sync.sv
// Purpose : two-flop synchroniser for asynchronous pad inputs
// Assumes : single destination clock
// Notes   : first stage feeds only the second stage

`timescale 1ns/10ps

module gpiors_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ---------------------------------------------------------------
  // two stages
  // ---------------------------------------------------------------
  // reset to zero keeps the chip held until the reset pin reads high
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

// >>> verification/gpiors_board.sv
// Purpose : board straps, host serial line and pad wiring around the block
// Assumes : pad levels resolve combinationally from pad_ctl and the board
// Notes   : an undriven pad with no pull wanders every cycle, never settles

`timescale 1ns/10ps

module gpiors_board
  import gpiors_pkg::*;
(
  input  wire logic                  clk,
  input  wire gpiors_pad_t [NPIN-1:0] pad_ctl,
  input  wire logic                  test_lo,
  input  wire logic                  boot_hi,
  input  wire logic                  rx_lvl,
  input  wire logic                  wake_lvl,
  output logic [NPIN-1:0]            pad_in
);
  logic flt_r = 1'b0;

  // floating level toggles so a missing pull cannot pass by luck
  always @(posedge clk) begin
    flt_r <= !flt_r;
  end

  // pad drive first, then pulls, then what the board forces
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pad_in[i] = pad_ctl[i].oe ? pad_ctl[i].out :
                  pad_ctl[i].pu ? 1'b1 : pad_ctl[i].pd ? 1'b0 : flt_r;
    end
    pad_in[PIN_WAKE] = wake_lvl;  // board resistor or wake source
    if (test_lo)
      pad_in[PIN_TX] = 1'b0;
    pad_in[PIN_RX]   = rx_lvl;
    pad_in[PIN_BOOT] = boot_hi;
  end
endmodule

// >>> verification/gpiors_tb_top.sv
// Purpose : self-checking bench for the gpio reset and strap block
// Assumes : start-up count shortened to 8 cycles, zero-wait apb slave
// Notes   : strap rows first, then firmware, wake and reset pin tests

`timescale 1ns/10ps

module gpiors_tb_top
  import gpiors_pkg::*;
;
  logic clk, reset, hw_reset_n, converter_enable, test_lo, boot_hi;
  logic rx_lvl, wake_lvl, sleep_active, ptx, stx, pwm, sdo;
  logic psel, penable, pwrite, pready, pslverr, err, prx, srx, spi_din;
  logic wake_req, converter_on, test_mode, download_mode;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [NPIN-1:0]          pad_in;
  gpiors_pad_t [NPIN-1:0]   pad_ctl;
  int                       n_mismatch = 0, n_tests = 0;
  // rows: test strap low, boot strap high, test mode, download mode
  logic [3:0] rows [4] = '{4'b0000, 4'b1010, 4'b0101, 4'b1110};

  gpiors_top #(.STARTUP_CYCLES(16'h0008)) dut_u (.clk(clk), .reset(reset),
    .hw_reset_n(hw_reset_n), .converter_enable(converter_enable),
    .pad_in(pad_in), .pad_ctl(pad_ctl), .primary_serial_tx(ptx),
    .secondary_serial_tx(stx), .spi_dout(sdo), .pulse_width_out(pwm),
    .sleep_active(sleep_active), .primary_serial_rx(prx),
    .secondary_serial_rx(srx), .spi_din(spi_din), .wake_req(wake_req),
    .converter_on(converter_on), .test_mode(test_mode),
    .download_mode(download_mode), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  gpiors_board brd_u (.clk(clk), .pad_ctl(pad_ctl), .test_lo(test_lo),
    .boot_hi(boot_hi), .rx_lvl(rx_lvl), .wake_lvl(wake_lvl),
    .pad_in(pad_in));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // full reset with straps set, then wait for the active state
  task automatic do_reset(input logic tl, input logic bh);
    reset <= 1'b1;
    test_lo <= tl;
    boot_hi <= bh;
    rx_lvl <= 1'b1;
    repeat (10) @(posedge clk);
    chk("reset pads", {6'h08, 6'h08, 6'h08, 18'h0}, pad_ctl);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd = 32'h0;
    while (rd[ST_RUN] !== 1'b1) apb(1'b0, STAT_OFS, 32'h0);
  endtask

  // hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    conclude;
  end

  initial begin
    {reset, hw_reset_n, converter_enable, rx_lvl} = 4'hF;
    {test_lo, boot_hi, wake_lvl, sleep_active, ptx, stx, pwm, sdo} = 8'h00;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    foreach (rows[i]) begin
      do_reset(rows[i][3], rows[i][2]);
      chk("modes", rows[i][1:0], {test_mode, download_mode});
      test_lo <= !rows[i][3];
      boot_hi <= !rows[i][2];
      rx_lvl <= 1'b0;
      repeat (8) @(posedge clk);
      chk("held", rows[i][1:0], {test_mode, download_mode});
      chk("rx route", rows[i][0], prx);
      chk("low pads", 18'h0, pad_ctl[2:0]);
      if (rows[i][0]) begin
        chk("tx dl", 3'b011, {pad_ctl[3].oe, pad_ctl[3].pu,
            pad_ctl[3].ie});
        chk("rx dl", 3'b011, {pad_ctl[4].oe, pad_ctl[4].pu,
            pad_ctl[4].ie});
      end else begin
        chk("tx start", 3'b100, {pad_ctl[3].oe, pad_ctl[3].pu,
            pad_ctl[3].pd});
        chk("rx start", 3'b100, {pad_ctl[4].ie, pad_ctl[4].pu,
            pad_ctl[4].pd});
      end
      $display("strap row %0d done", i);
    end
    // firmware: wake, pwm, secondary tx, spi in, tx pull-up
    do_reset(1'b0, 1'b0);
    apb(1'b1, FUNC_OFS, 32'h0000_03B2);
    apb(1'b1, PULL_OFS, 32'h0000_0008);
    apb(1'b0, FUNC_OFS, 32'h0);
    chk("func rd", 32'h0000_03B2, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 1'b1, err);
    stx <= 1'b1;
    pwm <= 1'b1;
    sleep_active <= 1'b1;
    wake_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    chk("tx sec", 3'b111, {pad_ctl[3].oe, pad_ctl[3].out,
        pad_ctl[3].pu});
    chk("pwm", 2'b11, {pad_ctl[2].oe, pad_ctl[2].out});
    chk("spi in", 1'b1, spi_din);
    chk("wake", 1'b1, wake_req);
    wake_lvl <= 1'b0;
    converter_enable <= 1'b0;
    rx_lvl <= 1'b0;
    repeat (6) @(posedge clk);
    chk("no wake", 1'b0, wake_req);
    chk("conv off", 1'b0, converter_on);
    chk("spi low", 1'b0, spi_din);
    chk("sec idle", 1'b1, srx);
    converter_enable <= 1'b1;
    repeat (6) @(posedge clk);
    chk("conv on", 1'b1, converter_on);
    apb(1'b1, FUNC_OFS, 32'h0000_03F2);
    sdo <= 1'b1;
    repeat (2) @(posedge clk);
    chk("tx spi", 2'b11, {pad_ctl[3].oe, pad_ctl[3].out});
    $display("firmware test done");
    // reset pin holds the pads and the apb slave in reset
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("pin rst", {6'h08, 6'h08, 6'h08, 18'h0}, pad_ctl);
    chk("pin rdy", 1'b0, pready);
    hw_reset_n <= 1'b1;
    rd = 32'h0;
    while (rd[ST_RUN] !== 1'b1) apb(1'b0, STAT_OFS, 32'h0);
    apb(1'b0, FUNC_OFS, 32'h0);
    chk("func back", FUNC_RST, rd);
    $display("reset pin test done");
    conclude;
  end
endmodule
